/* File: src/dma_defines.vh */
// Register offsets, field positions and reset values of the transfer and search engine
`ifndef DMA_DEFINES_VH
`define DMA_DEFINES_VH
`define OFF_CTRL 8'h00
`define OFF_CMD 8'h04
`define OFF_BUF_A 8'h08
`define OFF_BUF_B 8'h0c
`define OFF_LEN 8'h10
`define OFF_MATCH 8'h14
`define OFF_STAT 8'h18
`define OFF_CNT 8'h1c
`define OFF_CUR_A 8'h20
`define OFF_CUR_B 8'h24
// Control word fields
`define C_XFER 0
`define C_SRCH 1
`define C_MODE 3:2
`define C_DIR 4
`define C_A_IO 5
`define C_B_IO 6
`define C_A_STEP 8:7
`define C_B_STEP 10:9
`define C_STOP_MATCH 11
`define C_INT_MATCH 12
`define C_INT_END 13
`define C_AUTO 14
`define C_FLAG_ALL 15
`define C_A_LEN 17:16
`define C_B_LEN 19:18
`define C_A_EARLY 20
`define C_B_EARLY 21
`define CTRL_RST 32'h00000000
// Command word bits
`define K_ENABLE 0
`define K_LOAD 1
`define K_CLEAR 2
`define K_DISABLE 3
// Mode and step codes
`define MODE_BYTE 2'h0
`define MODE_BURST 2'h1
`define STEP_INC 2'h1
`define STEP_DEC 2'h2
// Shortest access, in clocks
`define CYC_MIN 3'h2
// Bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: src/pin_sync.v */
// Three-stage input synchroniser with agreement filter
module pin_sync #(
  parameter W = 5,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire ref_clk,
  input wire nrst,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  genvar i;

  // First stage is read by the second stage only
  always @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
    end
    else
    begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // A bit changes only once stages two and three agree
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      always @(posedge ref_clk)
      begin
        if (!nrst)
          q[i] <= INIT[i];
        else if (s2_reg[i] == s3_reg[i])
          q[i] <= s3_reg[i];
      end
    end
  endgenerate
endmodule

/* File: src/dma_engine.v */
// Single-channel transfer and search engine with register slave and bus master
//
// Overview of operation
// - Three classes: transfer, search, or both.
// - Engine owns address and data buses while running.
// - Each byte read from source, then written.
// - Each port independently memory or I/O.
// - Search compares read bytes with match byte.
// - Mask bits drop positions from the compare.
// - Combined class compares without extra reads.
// - Match or block end can halt or interrupt.
// - Status flags can reflect those same conditions.
// - Processor reads full status, count and addresses.
// - Byte mode releases buses after every byte.
// - Burst runs while ready, then finishes, releases.
// - Continuous holds buses until block completes.
// - Continuous pauses holding buses while not ready.
// - Separate source, destination addresses; fixed, up, down.
// - Sixteen-bit address bus for both ports.
// - Buffers written freely; counters load on load command while idle.
// - Auto restart repeats from buffered start addresses.
// - Per-port cycle length and early strobe end.
// - Bus and interrupt daisy chains need no glue.
// - Search-only runs one byte per read, two clocks at shortest.
// - Programmed length is byte count minus one.
// - A byte once read always completes in order.
// - Any control write disables until enable command.
// - Auto reload clears the byte counter too.
`include "dma_defines.vh"
module dma_engine #(
  parameter AW = 8
) (
  input wire ref_clk,
  input wire nrst,
  input wire [AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg [15:0] addr_out,
  input wire [7:0] data_in,
  output reg [7:0] data_out,
  output reg data_oe_n,
  output reg mreq_n,
  output reg iorq_n,
  output reg rd_n,
  output reg wr_n,
  input wire ready_a,
  input wire ready_b,
  input wire busreq_in_n,
  output reg busreq_out,
  output reg busreq_oe_n,
  input wire bus_ack_in_n,
  output reg bus_ack_out_n,
  output reg int_out,
  output reg int_oe_n,
  input wire int_chain_in,
  output reg int_chain_out
);
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_REQ = 3'h1;
  localparam [2:0] ST_READ = 3'h2;
  localparam [2:0] ST_WRITE = 3'h3;
  localparam [2:0] ST_PAUSE = 3'h4;
  localparam [2:0] ST_REL = 3'h5;

  reg [31:0] ctrl_reg;
  reg [15:0] buf_a_reg, buf_b_reg, len_reg;
  reg [7:0] match_reg, mask_reg;
  reg [AW-1:0] aw_reg;
  reg [31:0] wd_reg;
  reg [3:0] ws_reg;
  reg en_reg, en_next;
  reg [15:0] cur_a_reg, cur_a_next, cur_b_reg, cur_b_next;
  reg [15:0] cnt_reg, cnt_next;
  reg end_reg, end_next, hit_reg, hit_next, ipend_reg, ipend_next;
  reg now_hit_reg, now_hit_next;
  reg [7:0] hold_reg, hold_next;
  reg [2:0] st_reg, st_next;
  reg [1:0] t_reg, t_next;
  wire [4:0] pins_s;
  wire bai_n_s, other_n_s, rdy_a_s, rdy_b_s, iei_s;

  // Pins from other parties cross into this clock here
  pin_sync #(.W(5), .INIT(5'h13)) u_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .d({int_chain_in, ready_b, ready_a, busreq_in_n, bus_ack_in_n}),
    .q(pins_s)
  );
  assign bai_n_s = pins_s[0];
  assign other_n_s = pins_s[1];
  assign rdy_a_s = pins_s[2];
  assign rdy_b_s = pins_s[3];
  assign iei_s = pins_s[4];

  // Port selection follows the direction bit
  wire xfer = ctrl_reg[`C_XFER];
  wire srch = ctrl_reg[`C_SRCH];
  wire src_b = ctrl_reg[`C_DIR];
  wire [1:0] mode = ctrl_reg[`C_MODE];
  wire src_rdy = src_b ? rdy_b_s : rdy_a_s;
  wire [2:0] len_a = `CYC_MIN + {1'b0, ctrl_reg[`C_A_LEN] == 2'h3 ? 2'h2 : ctrl_reg[`C_A_LEN]};
  wire [2:0] len_b = `CYC_MIN + {1'b0, ctrl_reg[`C_B_LEN] == 2'h3 ? 2'h2 : ctrl_reg[`C_B_LEN]};
  wire [2:0] src_len = src_b ? len_b : len_a;
  wire [2:0] dst_len = src_b ? len_a : len_b;
  wire [2:0] ph_len = (st_reg == ST_READ) ? src_len : dst_len;
  wire last = ({1'b0, t_reg} == ph_len - 3'h1);
  wire src_io = src_b ? ctrl_reg[`C_B_IO] : ctrl_reg[`C_A_IO];
  wire dst_io = src_b ? ctrl_reg[`C_A_IO] : ctrl_reg[`C_B_IO];

  // Mask bit set means that position is ignored
  wire cmp_hit = (((data_in ^ match_reg) & ~mask_reg) == 8'h00);

  // Register write strobes
  wire wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire wr_map = (aw_reg == `OFF_CTRL) || (aw_reg == `OFF_CMD) ||
    (aw_reg == `OFF_BUF_A) || (aw_reg == `OFF_BUF_B) ||
    (aw_reg == `OFF_LEN) || (aw_reg == `OFF_MATCH);
  wire cfg_wr = wr_fire && wr_map && (aw_reg != `OFF_CMD);
  wire cmd_wr = wr_fire && (aw_reg == `OFF_CMD);
  wire [31:0] cmd = cmd_wr ? (wd_reg & {{8{ws_reg[3]}}, {8{ws_reg[2]}},
    {8{ws_reg[1]}}, {8{ws_reg[0]}}}) : 32'h00000000;

  function [31:0] mrg;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    reg [31:0] m;
    begin
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      mrg = (old & ~m) | (nw & m);
    end
  endfunction

  function [15:0] step;
    input [15:0] a;
    input [1:0] m;
    begin
      if (m == `STEP_INC)
        step = a + 16'h0001;
      else if (m == `STEP_DEC)
        step = a - 16'h0001;
      else
        step = a;
    end
  endfunction

  // Engine sequencing; a started byte runs to its end whatever ready does
  reg byte_done, blk_end, stop, set_end, set_hit, busy;
  always @*
  begin
    st_next = st_reg;
    t_next = t_reg;
    en_next = en_reg;
    cur_a_next = cur_a_reg;
    cur_b_next = cur_b_reg;
    cnt_next = cnt_reg;
    hold_next = hold_reg;
    now_hit_next = now_hit_reg;
    byte_done = 1'b0;
    blk_end = 1'b0;
    stop = 1'b0;
    set_end = 1'b0;
    set_hit = 1'b0;
    busy = (st_reg != ST_IDLE);
    case (st_reg)
      ST_IDLE:
      begin
        // Only start when nobody else pulls the shared request line
        if (en_reg && (xfer || srch) && src_rdy && other_n_s)
          st_next = ST_REQ;
      end
      ST_REQ:
      begin
        if (!bai_n_s)
        begin
          st_next = ST_READ;
          t_next = 2'h0;
        end
      end
      ST_READ:
      begin
        t_next = t_reg + 2'h1;
        if (last)
        begin
          hold_next = data_in;
          now_hit_next = srch && cmp_hit;
          t_next = 2'h0;
          if (xfer)
            st_next = ST_WRITE;
          else
            byte_done = 1'b1;
        end
      end
      ST_WRITE:
      begin
        t_next = t_reg + 2'h1;
        if (last)
        begin
          t_next = 2'h0;
          byte_done = 1'b1;
        end
      end
      ST_PAUSE:
      begin
        if (src_rdy)
          st_next = ST_READ;
      end
      ST_REL:
        st_next = ST_IDLE;
      default:
        st_next = ST_IDLE;
    endcase
    if (byte_done)
    begin
      blk_end = (cnt_reg == len_reg);
      cnt_next = cnt_reg + 16'h0001;
      // Source steps every byte, destination only when written
      if (src_b)
      begin
        cur_b_next = step(cur_b_reg, ctrl_reg[`C_B_STEP]);
        if (xfer)
          cur_a_next = step(cur_a_reg, ctrl_reg[`C_A_STEP]);
      end
      else
      begin
        cur_a_next = step(cur_a_reg, ctrl_reg[`C_A_STEP]);
        if (xfer)
          cur_b_next = step(cur_b_reg, ctrl_reg[`C_B_STEP]);
      end
      set_end = blk_end;
      // This byte's own result, else a search misses its last byte
      set_hit = now_hit_next;
      if (blk_end && ctrl_reg[`C_AUTO])
      begin
        cur_a_next = buf_a_reg;
        cur_b_next = buf_b_reg;
        cnt_next = 16'h0000;
      end
      if ((blk_end && !ctrl_reg[`C_AUTO]) || (now_hit_next && ctrl_reg[`C_STOP_MATCH]))
      begin
        stop = 1'b1;
        en_next = 1'b0;
      end
      if (stop || !en_reg || mode == `MODE_BYTE)
        st_next = ST_REL;
      else if (src_rdy)
        st_next = ST_READ;
      else if (mode == `MODE_BURST)
        st_next = ST_REL;
      else
        st_next = ST_PAUSE;
    end
    // Any control write stops the engine at the next byte boundary
    if (cfg_wr)
      en_next = 1'b0;
    if (cmd[`K_DISABLE])
      en_next = 1'b0;
    if (cmd[`K_ENABLE])
      en_next = 1'b1;
    // Working counters load only while the engine is idle, which in byte mode includes the gap between bytes
    if (cmd[`K_LOAD] && !busy)
    begin
      cur_a_next = buf_a_reg;
      cur_b_next = buf_b_reg;
      cnt_next = 16'h0000;
    end
  end

  // Status flags: hardware set beats a software clear in the same cycle
  wire flag_all = ctrl_reg[`C_FLAG_ALL];
  wire tell_end = flag_all || ctrl_reg[`C_INT_END] || !ctrl_reg[`C_AUTO];
  wire tell_hit = flag_all || ctrl_reg[`C_INT_MATCH] || ctrl_reg[`C_STOP_MATCH];
  always @*
  begin
    end_next = cmd[`K_CLEAR] ? 1'b0 : end_reg;
    hit_next = cmd[`K_CLEAR] ? 1'b0 : hit_reg;
    ipend_next = cmd[`K_CLEAR] ? 1'b0 : ipend_reg;
    if (set_end && tell_end)
      end_next = 1'b1;
    if (set_hit && tell_hit)
      hit_next = 1'b1;
    if ((set_end && ctrl_reg[`C_INT_END]) || (set_hit && ctrl_reg[`C_INT_MATCH]))
      ipend_next = 1'b1;
  end

  // Bus pin values for the coming cycle, derived from next state
  wire owning = (st_next == ST_READ) || (st_next == ST_WRITE) || (st_next == ST_PAUSE);
  wire rd_ph = (st_next == ST_READ);
  wire acc = rd_ph || (st_next == ST_WRITE);
  wire src_b_early = src_b ? ctrl_reg[`C_B_EARLY] : ctrl_reg[`C_A_EARLY];
  wire dst_b_early = src_b ? ctrl_reg[`C_A_EARLY] : ctrl_reg[`C_B_EARLY];
  wire early = rd_ph ? src_b_early : dst_b_early;
  wire [2:0] nlen = rd_ph ? src_len : dst_len;
  // Early end trims the last clock; a two-clock access keeps its strobe
  wire cut = early && (nlen > `CYC_MIN) && ({1'b0, t_next} == nlen - 3'h1);
  wire io_ph = rd_ph ? src_io : dst_io;
  wire [15:0] src_addr = src_b ? cur_b_next : cur_a_next;
  wire [15:0] dst_addr = src_b ? cur_a_next : cur_b_next;
  wire asking = owning || (st_next == ST_REQ);

  always @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      st_reg <= ST_IDLE;
      t_reg <= 2'h0;
      en_reg <= 1'b0;
      cur_a_reg <= 16'h0000;
      cur_b_reg <= 16'h0000;
      cnt_reg <= 16'h0000;
      hold_reg <= 8'h00;
      now_hit_reg <= 1'b0;
      end_reg <= 1'b0;
      hit_reg <= 1'b0;
      ipend_reg <= 1'b0;
      addr_out <= 16'h0000;
      data_out <= 8'h00;
      data_oe_n <= 1'b1;
      mreq_n <= 1'b1;
      iorq_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      busreq_out <= 1'b0;
      busreq_oe_n <= 1'b1;
      bus_ack_out_n <= 1'b1;
      int_out <= 1'b0;
      int_oe_n <= 1'b1;
      int_chain_out <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      t_reg <= t_next;
      en_reg <= en_next;
      cur_a_reg <= cur_a_next;
      cur_b_reg <= cur_b_next;
      cnt_reg <= cnt_next;
      hold_reg <= hold_next;
      now_hit_reg <= now_hit_next;
      end_reg <= end_next;
      hit_reg <= hit_next;
      ipend_reg <= ipend_next;
      addr_out <= (st_next == ST_WRITE) ? dst_addr : src_addr;
      data_out <= hold_next;
      data_oe_n <= !(st_next == ST_WRITE);
      mreq_n <= !(acc && !io_ph && !cut);
      iorq_n <= !(acc && io_ph && !cut);
      rd_n <= !(rd_ph && t_next != 2'h0 && !cut);
      wr_n <= !(st_next == ST_WRITE && t_next != 2'h0 && !cut);
      busreq_out <= 1'b0;
      busreq_oe_n <= !asking;
      // Acknowledge passes down the chain only when this engine is not asking
      bus_ack_out_n <= bai_n_s || asking;
      int_out <= 1'b0;
      int_oe_n <= !(ipend_next && iei_s);
      int_chain_out <= iei_s && !ipend_next;
    end
  end

  // Strobe-merged write data; narrow registers keep the low half
  wire [31:0] buf_a_w32 = mrg({16'h0000, buf_a_reg}, wd_reg, ws_reg);
  wire [31:0] buf_b_w32 = mrg({16'h0000, buf_b_reg}, wd_reg, ws_reg);
  wire [31:0] len_w32 = mrg({16'h0000, len_reg}, wd_reg, ws_reg);
  wire [31:0] match_w = mrg({16'h0000, mask_reg, match_reg}, wd_reg, ws_reg);

  // Configuration registers; buffer writes leave working counters alone
  always @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      ctrl_reg <= `CTRL_RST;
      buf_a_reg <= 16'h0000;
      buf_b_reg <= 16'h0000;
      len_reg <= 16'h0000;
      match_reg <= 8'h00;
      mask_reg <= 8'h00;
    end
    else if (cfg_wr)
    begin
      case (aw_reg)
        `OFF_CTRL: ctrl_reg <= mrg(ctrl_reg, wd_reg, ws_reg);
        `OFF_BUF_A: buf_a_reg <= buf_a_w32[15:0];
        `OFF_BUF_B: buf_b_reg <= buf_b_w32[15:0];
        `OFF_LEN: len_reg <= len_w32[15:0];
        `OFF_MATCH:
        begin
          match_reg <= match_w[7:0];
          mask_reg <= match_w[15:8];
        end
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // Readback of configuration, flags, progress and addresses
  wire own_w = (st_reg == ST_READ) || (st_reg == ST_WRITE) || (st_reg == ST_PAUSE);
  reg [31:0] rd_mux;
  reg rd_ok;
  always @*
  begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `OFF_CTRL: rd_mux = ctrl_reg;
      `OFF_CMD: rd_mux = 32'h00000000;
      `OFF_BUF_A: rd_mux = {16'h0000, buf_a_reg};
      `OFF_BUF_B: rd_mux = {16'h0000, buf_b_reg};
      `OFF_LEN: rd_mux = {16'h0000, len_reg};
      `OFF_MATCH: rd_mux = {16'h0000, mask_reg, match_reg};
      `OFF_STAT: rd_mux = {25'h0000000, busy, en_reg, own_w, ipend_reg, hit_reg,
        end_reg, src_rdy};
      `OFF_CNT: rd_mux = {16'h0000, cnt_reg};
      `OFF_CUR_A: rd_mux = {16'h0000, cur_a_reg};
      `OFF_CUR_B: rd_mux = {16'h0000, cur_b_reg};
      default:
      begin
        rd_mux = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end

  // Slave handshakes: address and data taken in either order, one write at a time
  always @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
      aw_reg <= {AW{1'b0}};
      wd_reg <= 32'h00000000;
      ws_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wd_reg <= s_axi_wdata;
        ws_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

/* File: sim/dma_engine_assertions.sv */
// Concurrent checks on the engine's system bus, chains and status read port
module dma_engine_checker (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [15:0] addr_out,
  input wire logic mreq_n,
  input wire logic iorq_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic data_oe_n,
  input wire logic busreq_out,
  input wire logic busreq_oe_n,
  input wire logic bus_ack_in_n,
  input wire logic bus_ack_out_n,
  input wire logic int_out,
  input wire logic int_oe_n,
  input wire logic int_chain_out,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  a_strobe_owned: assert property ((!mreq_n || !iorq_n) |-> !busreq_oe_n && $past(!bus_ack_in_n))
    else $error("strobe driven without bus grant");
  a_one_space: assert property (!(!mreq_n && !iorq_n))
    else $error("memory and io strobes together");
  a_rd_wr_apart: assert property (!(!rd_n && !wr_n))
    else $error("read and write strobes together");
  a_write_drives: assert property (!wr_n |-> !data_oe_n && rd_n)
    else $error("write strobe without data drive");
  a_rd_in_access: assert property (!rd_n |-> (!mreq_n || !iorq_n))
    else $error("read strobe outside an access");
  a_addr_hold: assert property ((!rd_n && $past(!rd_n)) || (!wr_n && $past(!wr_n)) |-> $stable(addr_out))
    else $error("address moved within an access");
  a_ack_blocked: assert property (!busreq_oe_n && $past(!busreq_oe_n) |-> bus_ack_out_n)
    else $error("grant passed on while requesting");
  a_int_chain: assert property (!int_oe_n |-> !int_chain_out)
    else $error("chain enabled while interrupt pending");
  a_open_drain: assert property (busreq_out == 1'b0 && int_out == 1'b0)
    else $error("open drain output driven high");
  a_status_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("status read not answered");
  // Main bus activity seen at least once
  c_io_read: cover property (!rd_n && !iorq_n);
  c_mem_write: cover property (!wr_n && !mreq_n);
  c_release: cover property ($rose(busreq_oe_n));
endmodule

/* File: sim/sys_bus_model.sv */
// Host processor, memory and io ports on the far side of the system bus
module sys_bus_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [3:0] ack_wait,
  input wire logic [15:0] addr_out,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  input wire logic mreq_n,
  input wire logic iorq_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic busreq_oe_n,
  output logic [7:0] data_in,
  output logic bus_ack_in_n = 1'b1,
  output logic busreq_in_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  logic [7:0] io [0:255];
  logic [7:0] last = 8'h00;
  logic [3:0] wait_cnt = 4'h0;
  // Request line has a pull-up; only the engine pulls it here
  assign busreq_in_n = busreq_oe_n;
  // Undriven data toggles every cycle so stale values never look valid
  assign data_in = (!rd_n && !mreq_n) ? mem[addr_out[7:0]] :
    (!rd_n && !iorq_n) ? io[addr_out[7:0]] : ~last;
  always @(posedge ref_clk)
  begin
    last <= data_in;
    if (!wr_n && !data_oe_n && !mreq_n)
      mem[addr_out[7:0]] <= data_out;
    else if (!wr_n && !data_oe_n && !iorq_n)
      io[addr_out[7:0]] <= data_out;
  end
  // Grant after a programmable delay, withdraw at once on release
  always @(posedge ref_clk)
  begin
    if (!nrst || busreq_in_n)
    begin
      wait_cnt <= 4'h0;
      bus_ack_in_n <= 1'b1;
    end
    else if (wait_cnt < ack_wait)
      wait_cnt <= wait_cnt + 4'h1;
    else
      bus_ack_in_n <= 1'b0;
  end
endmodule

/* File: sim/dma_engine_test.sv */
// Self-checking bench for the transfer and search engine
`include "dma_defines.vh"
module dma_engine_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, nrst = 1'b0, ready_a = 1'b1, ready_b = 1'b1, int_chain_in = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, st, cb;
  logic [15:0] addr_out;
  logic [7:0] data_in, data_out;
  logic data_oe_n, mreq_n, iorq_n, rd_n, wr_n, busreq_in_n, busreq_out, busreq_oe_n;
  logic bus_ack_in_n, bus_ack_out_n, int_out, int_oe_n, int_chain_out;
  logic [3:0] ack_wait = 4'h1;
  logic [1:0] rsp;
  integer n_errors = 0, tests_run = 0, cyc = 0, n_rd, n_wr, n_grant, w_cnt = 0, rd_w, i;
  dma_engine dma_engine_i (.ref_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .addr_out, .data_in,
    .data_out, .data_oe_n, .mreq_n, .iorq_n, .rd_n, .wr_n, .ready_a, .ready_b, .busreq_in_n,
    .busreq_out, .busreq_oe_n, .bus_ack_in_n, .bus_ack_out_n, .int_out, .int_oe_n,
    .int_chain_in, .int_chain_out);
  sys_bus_model sys_bus_model_i (.ref_clk, .nrst, .ack_wait, .addr_out, .data_out,
    .data_oe_n, .mreq_n, .iorq_n, .rd_n, .wr_n, .busreq_oe_n, .data_in, .bus_ack_in_n,
    .busreq_in_n);
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end
  // Strobe and bus request counters, and width of the last read strobe
  always @(negedge rd_n) n_rd++;
  always @(negedge wr_n) n_wr++;
  always @(negedge busreq_oe_n) n_grant++;
  always @(posedge ref_clk)
  begin
    cyc++;
    if (!rd_n)
      w_cnt++;
    else if (w_cnt != 0)
    begin
      rd_w = w_cnt;
      w_cnt = 0;
    end
    if (cyc == 30000)
    begin
      n_errors++;
      conclude();
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // Write cycle: address and data offered together, each dropped once taken
  task axw(input [7:0] a, input [31:0] d, input [1:0] er);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask
  task axr(input [7:0] a, output [31:0] d, output [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge ref_clk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  // Program a sequence, load counters, clear status and enable
  task cfg(input [31:0] c, input [31:0] a, input [31:0] b, input [31:0] n, input [31:0] m);
    axw(`OFF_CTRL, c, `RESP_OKAY);
    axw(`OFF_BUF_A, a, `RESP_OKAY);
    axw(`OFF_BUF_B, b, `RESP_OKAY);
    axw(`OFF_LEN, n, `RESP_OKAY);
    axw(`OFF_MATCH, m, `RESP_OKAY);
    axw(`OFF_CMD, 32'h6, `RESP_OKAY);
    n_rd = 0;
    n_wr = 0;
    n_grant = 0;
    axw(`OFF_CMD, 32'h1, `RESP_OKAY);
  endtask
  task wait_done;
    for (i = 0; i < 500; i++)
    begin
      axr(`OFF_STAT, st, rsp);
      if (st[5] === 1'b0)
        break;
    end
  endtask
  task t_regs;
    axr(`OFF_CTRL, st, rsp);
    chk(st, `CTRL_RST);
    axr(8'h30, st, rsp);
    chk({st, rsp}, {32'h0, `RESP_SLVERR});
    axw(`OFF_STAT, 32'h0, `RESP_SLVERR);
  endtask
  task t_mem_cont;
    for (i = 0; i < 4; i++)
      sys_bus_model_i.mem[8'h10 + i] = 8'h11 * (i + 1);
    cfg(32'h8289, 32'h10, 32'h40, 32'h3, 32'h0);
    wait_done();
    chk(st[1], 32'h1);
    chk(n_grant, 32'h1);
    chk({n_rd[7:0], n_wr[7:0]}, 16'h0404);
    for (i = 0; i < 4; i++)
      chk(sys_bus_model_i.mem[8'h40 + i], 8'h11 * (i + 1));
  endtask
  task t_io_byte;
    ack_wait <= 4'h4;
    sys_bus_model_i.io[5] = 8'h5a;
    cfg(32'ha221, 32'h05, 32'h80, 32'h2, 32'h0);
    wait_done();
    chk(n_grant, 32'h3);
    chk({int_oe_n, int_chain_out}, 2'h0);
    int_chain_in <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk({int_oe_n, int_chain_out}, 2'h2);
    int_chain_in <= 1'b1;
    for (i = 0; i < 3; i++)
      chk(sys_bus_model_i.mem[8'h80 + i], 8'h5a);
  endtask
  task t_search;
    ack_wait <= 4'h1;
    for (i = 0; i < 8; i++)
      sys_bus_model_i.mem[8'h38 + i] = 8'h00;
    sys_bus_model_i.mem[8'h3f] = 8'h15;
    sys_bus_model_i.mem[8'h3e] = 8'hb5;
    sys_bus_model_i.mem[8'h3d] = 8'ha0;
    cfg(32'h28902, 32'h3f, 32'h0, 32'h7, 32'h0fa5);
    wait_done();
    chk(st[2:1], 2'h2);
    chk(n_wr, 32'h0);
    chk(n_rd, 32'h3);
    chk(rd_w, 32'h3);
  endtask
  // Byte mode with auto restart, stopped by the disable command
  task t_auto;
    sys_bus_model_i.mem[8'h50] = 8'h71;
    sys_bus_model_i.mem[8'h51] = 8'h72;
    cfg(32'hc281, 32'h50, 32'h60, 32'h1, 32'h0);
    for (i = 0; i < 400 && n_wr < 3; i++)
      @(posedge ref_clk);
    axw(`OFF_CMD, 32'h8, `RESP_OKAY);
    repeat (30) @(posedge ref_clk);
    axr(`OFF_CNT, st, rsp);
    axr(`OFF_CUR_B, cb, rsp);
    chk(n_wr > 2 && st < 2, 32'h1);
    chk(cb - st, 32'h60);
    chk({sys_bus_model_i.mem[8'h60], sys_bus_model_i.mem[8'h61]}, 16'h7172);
  endtask
  task t_burst;
    ready_b <= 1'b0;
    sys_bus_model_i.io[9] = 8'h33;
    cfg(32'h80d7, 32'hc0, 32'h09, 32'h3f, 32'hff);
    axr(`OFF_STAT, st, rsp);
    chk(st[5], 32'h1);
    axw(`OFF_LEN, 32'h3f, `RESP_OKAY);
    axr(`OFF_STAT, st, rsp);
    chk(st[5], 32'h0);
    axw(`OFF_CMD, 32'h1, `RESP_OKAY);
    ready_b <= 1'b1;
    for (i = 0; i < 400 && n_rd < 5; i++)
      @(posedge ref_clk);
    ready_b <= 1'b0;
    for (i = 0; i < 100 && !busreq_oe_n; i++)
      @(posedge ref_clk);
    axr(`OFF_STAT, st, rsp);
    chk(st[5:4], 2'h2);
    chk(n_rd === n_wr && n_rd < 64, 32'h1);
    ready_b <= 1'b1;
    wait_done();
    chk(n_rd, 32'd64);
    chk(n_grant > 1, 32'h1);
    chk(sys_bus_model_i.mem[8'hff], 8'h33);
  endtask
  task conclude;
    $display("errors %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    t_regs();
    t_mem_cont();
    t_io_byte();
    t_search();
    t_auto();
    t_burst();
    conclude();
  end
endmodule
bind dma_engine dma_engine_checker dma_engine_checker_i (.ref_clk, .nrst, .addr_out, .mreq_n,
  .iorq_n, .rd_n, .wr_n, .data_oe_n, .busreq_out, .busreq_oe_n, .bus_ack_in_n, .bus_ack_out_n,
  .int_out, .int_oe_n, .int_chain_out, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
